// ===== verilog/exec_misc_defs.vh
`ifndef EXEC_MISC_DEFS_VH
`define EXEC_MISC_DEFS_VH

// ------------------------------------------------------------
// operation codes presented by the decode stage
// ------------------------------------------------------------
`define OP_W            3
`define OP_NOP          3'h0
`define OP_LOAD_PRESC   3'h1
`define OP_SOFT_RESET   3'h2
`define OP_IRQ_RETURN   3'h3
`define OP_SUB_RETURN   3'h4
`define OP_RET_LITERAL  3'h5
`define OP_ROTATE_LEFT  3'h6

// ------------------------------------------------------------
// widths, field positions and reset values
// ------------------------------------------------------------
`define DATA_W          8
`define ADDR_W          7
`define PC_W            15
`define IRQ_EN_BIT      7
`define MSB_BIT         7
`define DEST_ACC        1'b0
`define DEST_FILE       1'b1
`define PRESC_RST       8'hff
`define IRQCTL_RST      8'h00
`define ACC_RST         8'h00
`define PC_RST          15'h0000
`define PC_STEP         15'h0001
`define CARRY_RST       1'b0
`define CAUSE_FLAG_RST  1'b1

// ------------------------------------------------------------
// sequencer states and cycle counts
// ------------------------------------------------------------
`define ST_W            2
`define ST_EXEC         2'h0
`define ST_FLUSH        2'h1
`define ST_RESET        2'h2
`define RESET_CYC       2'h2

`endif

// ===== verilog/rot_left_carry.v
`timescale 1ns/1ps
`default_nettype none
`include "exec_misc_defs.vh"

// one-position left rotate through the carry, purely combinational
module rot_left_carry (
	// operand and carry in
	input  wire [`DATA_W-1:0] src,
	input  wire               carry_in,
	// result and carry out
	output wire [`DATA_W-1:0] result,
	output wire               carry_out
);

	// old carry enters bit 0, old msb leaves as carry
	assign result    = {src[`DATA_W-2:0], carry_in};
	assign carry_out = src[`MSB_BIT];

endmodule // rot_left_carry

`default_nettype wire

// ===== verilog/return_rotate_misc_instr_exec.v
// Notes on behaviour
// - load-prescaler op copies accumulator to prescaler config; no flags.
// - soft reset op resets device and clears reset_instr_flag_n.
// - irq_return_op pops stack, pc from stack_top, sets bit 7; 2 cycles.
// - subroutine return pops stack, pc from stack_top; two cycles, no flags.
// - return_literal_op puts literal in accumulator, pops to pc; 2 cycles.
// - rotate_left_carry_op shifts left; old carry in bit 0, msb to carry.
// - destination 0 writes accumulator, 1 writes back the file register.
// - rotate takes a 7-bit file address, 0..127, in current bank.
`timescale 1ns/1ps
`default_nettype none
`include "exec_misc_defs.vh"

module return_rotate_misc_instr_exec (
	// clock and reset
	input  wire                sys_clk,
	input  wire                arst_n,
	// decoded instruction
	input  wire                instr_valid,
	input  wire [`OP_W-1:0]    instr_op,
	input  wire [`DATA_W-1:0]  instr_literal,
	input  wire [`ADDR_W-1:0]  instr_faddr,
	input  wire                instr_dest,
	output wire                instr_ready,
	// return stack
	input  wire [`PC_W-1:0]    stack_top,
	output wire                stack_pop,
	// file register port, read is combinational
	output wire [`ADDR_W-1:0]  file_addr,
	input  wire [`DATA_W-1:0]  file_rdata,
	output reg                 file_we_r,
	output reg  [`DATA_W-1:0]  file_wdata_r,
	// architectural state
	output reg  [`PC_W-1:0]    pc_r,
	output reg  [`DATA_W-1:0]  accum_r,
	output reg                 carry_r,
	output reg  [`DATA_W-1:0]  presc_cfg_r,
	output reg  [`DATA_W-1:0]  irq_control_reg_r,
	// reset cause and request
	output reg                 reset_instr_flag_n_r,
	output reg                 soft_reset_req_r
);

	// ------------------------------------------------------------
	// internal state
	// ------------------------------------------------------------
	reg  [`ST_W-1:0]   state_r;
	reg  [`ST_W-1:0]   state_nxt;
	reg  [1:0]         rst_cnt_r;
	reg  [1:0]         rst_cnt_nxt;
	reg  [`PC_W-1:0]   pc_nxt;
	reg  [`DATA_W-1:0] accum_nxt;
	reg                carry_nxt;
	wire               take;
	wire               in_reset;
	wire               is_presc;
	wire               is_soft_rst;
	wire               is_irq_ret;
	wire               is_lit_ret;
	wire               is_rotate;
	wire               rot_to_file;
	wire [`DATA_W-1:0] rot_res;
	wire               rot_c;

	// decode stalls during the flush cycle and the reset pulse
	assign instr_ready = (state_r == `ST_EXEC);
	assign take        = instr_valid & instr_ready;
	assign file_addr   = instr_faddr;
	// one pop per return, in its first cycle
	assign stack_pop   = take & ((instr_op == `OP_IRQ_RETURN) |
	                             (instr_op == `OP_SUB_RETURN) |
	                             (instr_op == `OP_RET_LITERAL));

	rot_left_carry u_rot (
		.src       (file_rdata),
		.carry_in  (carry_r),
		.result    (rot_res),
		.carry_out (rot_c)
	);

	// ------------------------------------------------------------
	// sequencer: returns spend a second cycle refilling the fetch
	// ------------------------------------------------------------
	always @* begin
		state_nxt = state_r;
		case (state_r)
			`ST_EXEC: begin
				if (take && stack_pop)
					state_nxt = `ST_FLUSH;
				else if (take && instr_op == `OP_SOFT_RESET)
					state_nxt = `ST_RESET;
			end
			`ST_FLUSH: state_nxt = `ST_EXEC;
			`ST_RESET: begin
				if (rst_cnt_r == `RESET_CYC)
					state_nxt = `ST_EXEC;
			end
			default: state_nxt = `ST_EXEC;
		endcase
	end

	// ------------------------------------------------------------
	// operation decode, qualified by the accepted strobe
	// ------------------------------------------------------------
	// qualifying here keeps a stalled op from touching any state
	assign in_reset    = (state_r == `ST_RESET);
	assign is_presc    = take & (instr_op == `OP_LOAD_PRESC);
	assign is_soft_rst = take & (instr_op == `OP_SOFT_RESET);
	assign is_irq_ret  = take & (instr_op == `OP_IRQ_RETURN);
	assign is_lit_ret  = take & (instr_op == `OP_RET_LITERAL);
	assign is_rotate   = take & (instr_op == `OP_ROTATE_LEFT);
	assign rot_to_file = is_rotate & (instr_dest == `DEST_FILE);

	// ------------------------------------------------------------
	// length of the internal reset pulse
	// ------------------------------------------------------------
	// restarts on every accepted soft reset, then runs to its end
	always @* begin
		rst_cnt_nxt = rst_cnt_r;
		if (is_soft_rst)
			rst_cnt_nxt = 2'h0;
		else if (in_reset)
			rst_cnt_nxt = rst_cnt_r + 2'h1;
	end

	// ------------------------------------------------------------
	// next values of the program counter, accumulator and carry
	// ------------------------------------------------------------
	// returns jump to the popped address, every other op steps by one;
	// the reset pulse cannot clash, no op is accepted while it stands
	always @* begin
		pc_nxt = pc_r;
		if (in_reset)
			pc_nxt = `PC_RST;
		else if (stack_pop)
			pc_nxt = stack_top;
		else if (take)
			pc_nxt = pc_r + `PC_STEP;
	end

	// besides the reset pulse, only the literal return and the rotate touch accumulator or carry;
	// a nop or a plain return falls through and leaves both alone
	always @* begin
		accum_nxt = accum_r;
		carry_nxt = carry_r;
		if (in_reset) begin
			accum_nxt = `ACC_RST;
			carry_nxt = `CARRY_RST;
		end else if (is_lit_ret) begin
			accum_nxt = instr_literal;
		end else if (is_rotate) begin
			carry_nxt = rot_c;
			if (instr_dest == `DEST_ACC)
				accum_nxt = rot_res;
		end
	end

	// ------------------------------------------------------------
	// registered state
	// ------------------------------------------------------------
	// core state and sequencer, loaded from the next values above
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r   <= `ST_EXEC;
			rst_cnt_r <= 2'h0;
			pc_r      <= `PC_RST;
			accum_r   <= `ACC_RST;
			carry_r   <= `CARRY_RST;
		end else begin
			state_r   <= state_nxt;
			rst_cnt_r <= rst_cnt_nxt;
			pc_r      <= pc_nxt;
			accum_r   <= accum_nxt;
			carry_r   <= carry_nxt;
		end
	end

	// configuration registers, returned to defaults by the reset pulse
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			presc_cfg_r       <= `PRESC_RST;
			irq_control_reg_r <= `IRQCTL_RST;
		end else if (in_reset) begin
			presc_cfg_r       <= `PRESC_RST;
			irq_control_reg_r <= `IRQCTL_RST;
		end else begin
			if (is_presc)
				presc_cfg_r <= accum_r;
			if (is_irq_ret)
				irq_control_reg_r[`IRQ_EN_BIT] <= 1'b1;
		end
	end

	// the cause flag survives the reset pulse so firmware can read it;
	// only the asynchronous (power-on) path sets it back
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reset_instr_flag_n_r <= `CAUSE_FLAG_RST;
			soft_reset_req_r     <= 1'b0;
		end else if (is_soft_rst) begin
			reset_instr_flag_n_r <= 1'b0;
			soft_reset_req_r     <= 1'b1;
		end else if (in_reset) begin
			// drops in the cycle that hands control back to decode
			soft_reset_req_r <= (rst_cnt_r != `RESET_CYC);
		end
	end

	// write strobe stands for one cycle after a file-bound rotate
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			file_we_r    <= 1'b0;
			file_wdata_r <= `ACC_RST;
		end else begin
			file_we_r <= rot_to_file;
			if (rot_to_file)
				file_wdata_r <= rot_res;
		end
	end

endmodule // return_rotate_misc_instr_exec

`default_nettype wire

// ===== test/exec_misc_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "exec_misc_defs.vh"
module exec_misc_chk (
	// clock, reset, decode side
	input wire logic sys_clk, arst_n, instr_valid, instr_dest, instr_ready,
	input wire logic [`OP_W-1:0] instr_op,
	input wire logic [`DATA_W-1:0] instr_literal, file_rdata, file_wdata_r,
	input wire logic [`ADDR_W-1:0] instr_faddr, file_addr,
	// stack and state
	input wire logic [`PC_W-1:0] stack_top, pc_r,
	input wire logic stack_pop, file_we_r, carry_r, reset_instr_flag_n_r,
	input wire logic soft_reset_req_r,
	input wire logic [`DATA_W-1:0] accum_r, presc_cfg_r, irq_control_reg_r
);
	// ----
	// accepted op at this edge
	// ----
	wire tk = instr_valid && instr_ready;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	presc_load_a: assert property (tk && instr_op == `OP_LOAD_PRESC
		|=> presc_cfg_r == $past(accum_r)) else $error("presc load bad");
	soft_reset_a: assert property (tk && instr_op == `OP_SOFT_RESET
		|=> !reset_instr_flag_n_r && soft_reset_req_r) else $error("sw rst bad");
	irq_return_a: assert property (tk && instr_op == `OP_IRQ_RETURN
		|-> stack_pop ##1 pc_r == $past(stack_top)
		&& irq_control_reg_r[`IRQ_EN_BIT]) else $error("irq return bad");
	sub_return_a: assert property (tk && instr_op == `OP_SUB_RETURN
		|-> stack_pop ##1 !instr_ready ##1 instr_ready) else $error("ret bad");
	lit_return_a: assert property (tk && instr_op == `OP_RET_LITERAL
		|=> accum_r == $past(instr_literal) && pc_r == $past(stack_top))
		else $error("literal return bad");
	rot_carry_a: assert property (tk && instr_op == `OP_ROTATE_LEFT
		|=> carry_r == $past(file_rdata[`MSB_BIT])) else $error("carry bad");
	rot_dest_a: assert property (tk && instr_op == `OP_ROTATE_LEFT
		|=> file_we_r == $past(instr_dest) && (file_we_r ? file_wdata_r
		: accum_r) == {$past(file_rdata[6:0]), $past(carry_r)})
		else $error("rotate dest bad");
	file_addr_a: assert property (file_addr == instr_faddr)
		else $error("file addr bad");
	nop_step_a: assert property (tk && instr_op == `OP_NOP
		|=> pc_r == $past(pc_r) + `PC_STEP && $stable(accum_r)
		&& $stable(carry_r)) else $error("nop bad");
	cover property (tk && instr_op == `OP_IRQ_RETURN);
	cover property (tk && instr_op == `OP_ROTATE_LEFT && instr_dest);
	cover property (tk && instr_op == `OP_SOFT_RESET);
endmodule // exec_misc_chk
bind return_rotate_misc_instr_exec exec_misc_chk exec_misc_chk_inst (.*);
`default_nettype wire

// ===== test/return_rotate_misc_instr_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "exec_misc_defs.vh"
module return_rotate_misc_instr_exec_tb;
	// ----
	// stimulus, outputs and expected state
	// ----
	logic sys_clk = 0, arst_n = 0, instr_valid = 0, instr_dest = 0, e_c = 0;
	logic [2:0] instr_op = 0;
	logic [7:0] instr_literal = 0, file_rdata = 0, e_acc = 0, e_presc = 8'hff;
	logic [7:0] e_irq = 0;
	logic [6:0] instr_faddr = 0;
	logic [14:0] stack_top = 0, e_pc = 0;
	logic [8:0] e_rot;
	wire instr_ready, stack_pop, file_we_r, carry_r;
	wire reset_instr_flag_n_r, soft_reset_req_r;
	wire [6:0] file_addr;
	wire [7:0] file_wdata_r, accum_r, presc_cfg_r, irq_control_reg_r;
	wire [14:0] pc_r;
	integer fail_count = 0, total_checks = 0, cyc = 0, seed = 32'h271a, i, w;
	return_rotate_misc_instr_exec return_rotate_misc_instr_exec_inst (.*);
	initial forever #10 sys_clk = ~sys_clk;
	// hang guard, far above the ~560 cycles needed
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			fail_count = fail_count + 1;
			conclude;
		end
	end
	task chk(input logic [14:0] s, input logic [14:0] e);
		total_checks = total_checks + 1;
		if (s !== e) begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task conclude;
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// expected rotate: new carry on top, rotated byte below
	function automatic logic [8:0] rot_exp(logic [7:0] v, logic c);
		rot_exp = {v, c};
	endfunction
	// one instruction, waits out flush cycles first
	task run(input [2:0] op, input [7:0] k, input [7:0] rd, input [6:0] fa,
		input d);
		{instr_valid, instr_op, instr_literal, file_rdata} = {1'b1, op, k, rd};
		{instr_faddr, instr_dest, stack_top} = {fa, d, 15'($random(seed))};
		#1; // let the combinational outputs follow the new op
		for (w = 0; instr_ready !== 1'b1 && w < 8; w++) @(posedge sys_clk) #1;
		chk(stack_pop, op inside {3, 4, 5});
		chk(file_addr, fa);
		e_rot = rot_exp(rd, e_c);
		@(posedge sys_clk) #1;
		// valid stays high; the next call drives its op in this step
		chk(instr_ready, !(op inside {2, 3, 4, 5}));
		e_pc = (op inside {3, 4, 5}) ? stack_top : e_pc + 15'h1;
		if (op == 1) e_presc = e_acc;
		if (op == 3) e_irq[7] = 1'b1;
		if (op == 5) e_acc = k;
		if (op == 6) begin
			e_c = e_rot[8];
			if (!d) e_acc = e_rot[7:0];
			chk(file_we_r, d);
			if (d) chk(file_wdata_r, e_rot[7:0]);
		end
		if (op == 2) begin
			chk({reset_instr_flag_n_r, soft_reset_req_r}, 2'b01);
			repeat (3) @(posedge sys_clk);
			#1;
			{e_pc, e_acc, e_c, e_presc, e_irq} = {15'h0, 8'h0, 1'b0, 8'hff, 8'h0};
			chk(soft_reset_req_r, 1'b0);
		end
		chk(pc_r, e_pc);
		chk(accum_r, e_acc);
		chk(carry_r, e_c);
		chk(presc_cfg_r, e_presc);
		chk(irq_control_reg_r, e_irq);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		#1;
		arst_n = 1;
		run(6, 0, 8'he6, 7'h7f, 0);
		run(6, 0, 8'h80, 7'h00, 1);
		run(3, 0, 0, 0, 0);
		run(5, 8'hff, 0, 0, 0);
		run(4, 0, 0, 0, 0);
		run(1, 0, 0, 0, 0);
		run(0, 0, 0, 0, 0);
		run(2, 0, 0, 0, 0);
		// mid-run reset: only this path may set the cause flag again
		arst_n = 0;
		@(posedge sys_clk) #1;
		arst_n = 1;
		chk(reset_instr_flag_n_r, 1'b1);
		$display("test corner done");
		for (i = 0; i < 300; i++)
			run(3'($random(seed)), 8'($random(seed)), 8'($random(seed)),
				7'($random(seed)), 1'($random(seed)));
		$display("test random done");
		conclude;
	end
endmodule // return_rotate_misc_instr_exec_tb
`default_nettype wire
